//--- hw/wbra_top.sv
// Notes on behaviour
// - Write request carries 64-bit present and 32-bit odd flags, valid with it.
// - Unaligned write stuck in entry 0, not last written, drains whole buffer.
// - Single-ops bit makes buffer report full with any pending entry.
// - Drain-all bit requests every pending entry by chart priority, ignoring latch.
// - Last-written-disable includes latch entry; one pending acts like two.
// - Force-bad-parity drives all memory address parity bits to one.
// - Three microcode-only bits force the buffer pointer to a known value.
// - Memory write destination latches address and data, sets busy, raises request.
// - Cache miss or fast read latches address, sets busy, raises read request.
// - Buffer available when previous chain done, memory timer not using it, and an entry is free or hit.
// - Posted write plus available buffer gives pre-ack, registered to start chain.
// - Acknowledge shifts into four delayed copies, one beat each.
// - Latched address compared with four entries; any match with an entry holding valid bits raises hit.
// - First beat picks hit pointer on hit, else free pointer, for data write.
// - First beat holds input address and closes the request latch.
// - Second beat writes 32 or 64 data bits with write pulses spanning the whole beat.
// - Second beat stores address and sets pending; hit merges valid bits, miss replaces them.
// - Busy drops at third beat; pipeline requests stall while busy.
// - Third beat loads current pointer into the last-written latch.
// - Fourth beat ends the abort sequence of a write.
// - Normally the last-written entry is never requested.
// - If all candidates unaligned, with three pending or a drain, read request replaces write request.
// - Prefer 64-bit aligned, then 32-bit, then unaligned; ties to higher pointer.
// Purpose: Write buffer request selector and CPU write acknowledge chain.
// Assumes: One beat per ref_clk; half beats are the low phase of a toggle.
// Notes:   Valid bits are one per 16-bit half word, four per 64-bit entry.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "wbra_cfg.svh"
module wbra_top #(
  parameter int ADDR_W = 29
) (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              dest_write_64,
  input  wire logic              dest_write_32,
  input  wire logic              cache_miss,
  input  wire logic              fast_read_64_cmd,
  input  wire logic              dest_half,
  input  wire logic              half_odd,
  input  wire logic [ADDR_W-1:0] cpu_address_bus,
  input  wire logic [31:0]       cpu_data_bus,
  input  wire logic              mt_busy_with_wb,
  input  wire logic              mt_done,
  input  wire logic [1:0]        mt_done_ptr,
  output logic                   mem_busy_n,
  output logic                   mt_write_req,
  output logic                   mt_read_req,
  output logic                   mt_write_64,
  output logic                   mt_write_odd,
  output logic      [1:0]        mt_req_ptr,
  output logic                   wb_full,
  output logic                   abort_active,
  output logic      [3:0]        mem_addr_parity,
  output logic      [ADDR_W-1:0] memory_address_bus
);
  initial begin
    if (ADDR_W < 2 || ADDR_W > 32) $error("ADDR_W out of range");
  end

  logic [ADDR_W-1:0] addrEnt [4];
  logic [63:0]       dataEnt [4];
  logic [3:0]        validEnt [4];
  logic [3:0]        pendReg;
  logic [3:0]        diagReg;
  logic [2:0]        ptrInitReg;
  logic [1:0]        lastWrittenReg;
  logic [ADDR_W-1:0] addrLatchReg;
  logic [31:0]       dataLatchReg;
  logic              halfReg;
  logic              oddReg;
  logic              w64Reg;
  wbra_pkg::wbra_req_e reqReg;
  logic              busyReg;
  logic [3:0]        ackChain;
  logic              hitReg;
  logic [1:0]        ptrReg;
  logic              halfPhase;
  logic              drainReg;
  logic              gateReg;
  logic [3:0]        heldCand;

  logic [3:0] hitVec;
  logic       hitAny;
  logic [1:0] hitPtr;
  logic [1:0] freePtr;
  logic       anyFree;
  always_comb begin
    hitAny  = 1'b0;
    hitPtr  = 2'd0;
    freePtr = 2'd0;
    anyFree = 1'b0;
    for (int i = 0; i < 4; i++) begin
      hitVec[i] = (validEnt[i] != 4'h0) && (addrEnt[i] == addrLatchReg);
      if (hitVec[i]) begin
        hitAny = 1'b1;
        hitPtr = 2'(i);
      end
      if (validEnt[i] == 4'h0 && !pendReg[i]) begin
        anyFree = 1'b1;
        freePtr = 2'(i);
      end
    end
  end

  logic avail;
  assign avail = (ackChain == 4'h0) && !mt_busy_with_wb && (anyFree || hitAny);

  logic preAck;
  assign preAck = (reqReg == wbra_pkg::WBRA_WPOST) && avail;

  assign mem_busy_n = !busyReg;
  logic newWrite;
  logic newRead;
  assign newWrite = !busyReg && (dest_write_64 || dest_write_32);
  assign newRead  = !busyReg && !newWrite && (cache_miss || fast_read_64_cmd);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      addrLatchReg <= '0;
      dataLatchReg <= 32'h0000_0000;
      halfReg      <= 1'b0;
      oddReg       <= 1'b0;
      w64Reg       <= 1'b0;
    end else if ((newWrite || newRead) && !ackChain[0]) begin
      addrLatchReg <= cpu_address_bus;
      if (newWrite) begin
        dataLatchReg <= cpu_data_bus;
        halfReg      <= dest_half;
        oddReg       <= half_odd;
        w64Reg       <= dest_write_64;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reqReg  <= wbra_pkg::WBRA_IDLE;
      busyReg <= 1'b0;
    end else begin
      if (newWrite) begin
        reqReg  <= wbra_pkg::WBRA_WPOST;
        busyReg <= 1'b1;
      end else if (newRead) begin
        reqReg  <= wbra_pkg::WBRA_RPOST;
        busyReg <= 1'b1;
      end else if (preAck) begin
        reqReg <= wbra_pkg::WBRA_IDLE;
      end else if (reqReg == wbra_pkg::WBRA_RPOST && mt_done) begin
        reqReg  <= wbra_pkg::WBRA_IDLE;
        busyReg <= 1'b0;
      end
      if (ackChain[1]) begin
        busyReg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ackChain <= 4'h0;
    end else begin
      ackChain <= {ackChain[2:0], preAck};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hitReg <= 1'b0;
      ptrReg <= 2'd0;
    end else if (ptrInitReg[`WBRA_PTRINIT_EN]) begin
      ptrReg <= ptrInitReg[1:0];
    end else if (preAck) begin
      hitReg <= hitAny;
      ptrReg <= hitAny ? hitPtr : freePtr;
    end
  end

  // Half-beat phase: toggles each beat, high for one whole beat and low for the next.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      halfPhase <= 1'b0;
    end else begin
      halfPhase <= !halfPhase;
    end
  end

  // Write pulses, the whole of beat two.
  logic writeHi;
  logic writeLo;
  assign writeHi = ackChain[1] && (w64Reg || !oddReg);
  assign writeLo = ackChain[1] && (w64Reg || oddReg);

  // A half-word write validates one bit; otherwise a 64-bit write validates the whole entry, a 32-bit write only its own half.
  logic [3:0] newValid;
  assign newValid = halfReg ? (oddReg ? 4'h1 : 4'h2) :
                    w64Reg  ? 4'hF : (oddReg ? 4'h3 : 4'hC);

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gEnt
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          addrEnt[g]  <= '0;
          dataEnt[g]  <= 64'h0000_0000_0000_0000;
          validEnt[g] <= 4'h0;
          pendReg[g]  <= 1'b0;
        end else begin
          if (mt_done && mt_done_ptr == 2'(g)) begin
            pendReg[g] <= 1'b0;
          end
          if (ackChain[1] && ptrReg == 2'(g)) begin
            addrEnt[g] <= addrLatchReg;
            pendReg[g] <= 1'b1;
            validEnt[g] <= hitReg ? (validEnt[g] | newValid) : newValid;
            if (writeHi) begin
              dataEnt[g][63:32] <= dataLatchReg;
            end
            if (writeLo) begin
              dataEnt[g][31:0] <= dataLatchReg;
            end
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lastWrittenReg <= 2'd0;
    end else if (ackChain[2]) begin
      lastWrittenReg <= ptrReg;
    end
  end

  // Abort spans chain, ended by beat four.
  assign abort_active = |ackChain[2:0] || preAck;

  // Candidate classification per entry.
  wbra_pkg::wbra_class_e cls [4];
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!pendReg[i]) begin
        cls[i] = wbra_pkg::WBRA_CLS_NONE;
      end else if (validEnt[i] == 4'hF) begin
        cls[i] = wbra_pkg::WBRA_CLS_AL64;
      end else if (validEnt[i] == 4'hC || validEnt[i] == 4'h3) begin
        cls[i] = wbra_pkg::WBRA_CLS_AL32;
      end else begin
        cls[i] = wbra_pkg::WBRA_CLS_UNAL;
      end
    end
  end

  // Stuck unaligned entry zero starts a drain.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      drainReg <= 1'b0;
    end else if (pendReg == 4'h0) begin
      drainReg <= 1'b0;
    end else if (cls[0] == wbra_pkg::WBRA_CLS_UNAL && lastWrittenReg != 2'd0) begin
      drainReg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      gateReg <= 1'b0;
    end else begin
      gateReg <= preAck || |ackChain[1:0];
    end
  end

  logic [3:0] candMask;
  logic [2:0] candCount;
  logic       drainAll;
  wbra_pkg::wbra_class_e bestCls;
  logic [1:0] bestPtr;
  logic       reqWrite;
  logic       reqRead;
  always_comb begin
    drainAll  = diagReg[`WBRA_DIAG_DRAIN] || drainReg;
    candMask  = pendReg;
    if (!diagReg[`WBRA_DIAG_LWDIS] && !drainAll) begin
      candMask[lastWrittenReg] = 1'b0;
    end
    candCount = 3'd0;
    for (int i = 0; i < 4; i++) begin
      candCount = candCount + {2'b00, pendReg[i]};
    end
    if (diagReg[`WBRA_DIAG_LWDIS] && candCount == 3'd1) begin
      candCount = 3'd2;
    end
    // Priority by class then higher pointer.
    bestCls = wbra_pkg::WBRA_CLS_NONE;
    bestPtr = 2'd0;
    for (int i = 0; i < 4; i++) begin
      if (candMask[i] && cls[i] >= bestCls) begin
        bestCls = cls[i];
        bestPtr = 2'(i);
      end
    end
    reqWrite = 1'b0;
    reqRead  = 1'b0;
    if (drainAll || candCount >= 3'd3) begin
      reqWrite = bestCls == wbra_pkg::WBRA_CLS_AL64 || bestCls == wbra_pkg::WBRA_CLS_AL32;
      reqRead  = bestCls == wbra_pkg::WBRA_CLS_UNAL;
    end else if (candCount == 3'd2) begin
      reqWrite = bestCls == wbra_pkg::WBRA_CLS_AL64 || bestCls == wbra_pkg::WBRA_CLS_AL32;
    end
  end

  // Outputs held while the gate is closed.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mt_write_req <= 1'b0;
      mt_read_req  <= 1'b0;
      mt_write_64  <= 1'b0;
      mt_write_odd <= 1'b0;
      mt_req_ptr   <= 2'd0;
      heldCand     <= 4'h0;
    end else if (!gateReg && !preAck) begin
      mt_write_req <= reqWrite;
      mt_read_req  <= reqRead;
      mt_write_64  <= reqWrite && bestCls == wbra_pkg::WBRA_CLS_AL64;
      mt_write_odd <= reqWrite && bestCls == wbra_pkg::WBRA_CLS_AL32 &&
                      validEnt[bestPtr] == 4'h3;
      mt_req_ptr   <= bestPtr;
      heldCand     <= candMask;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wb_full <= 1'b0;
    end else if (diagReg[`WBRA_DIAG_SINGLE]) begin
      wb_full <= pendReg != 4'h0;
    end else begin
      wb_full <= pendReg == 4'hF;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      memory_address_bus <= '0;
      mem_addr_parity    <= 4'h0;
    end else begin
      memory_address_bus <= (reqReg == wbra_pkg::WBRA_RPOST) ? addrLatchReg : addrEnt[mt_req_ptr];
      if (diagReg[`WBRA_DIAG_BADPAR]) begin
        mem_addr_parity <= 4'hF;
      end else begin
        for (int b = 0; b < 4; b++) begin
          mem_addr_parity[b] <= ^(32'(addrEnt[mt_req_ptr]) >> (8 * b) & 32'h0000_00FF);
        end
      end
    end
  end

  // APB slave, zero wait states; unmapped reads give zero with an error.
  logic apbAcc;
  assign apbAcc  = psel && penable;
  assign pready  = 1'b1;
  logic mapped;
  assign mapped  = paddr == `WBRA_OFF_DIAG || paddr == `WBRA_OFF_STATUS ||
                   paddr == `WBRA_OFF_PTRINIT ||
                   (paddr >= `WBRA_OFF_ENTRYBASE && paddr < 12'h020);
  assign pslverr = apbAcc && !mapped;

  // Diagnostic bits, cleared at reset and by software.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      diagReg    <= `WBRA_DIAG_RESET;
      ptrInitReg <= 3'b000;
    end else if (apbAcc && pwrite && paddr == `WBRA_OFF_DIAG) begin
      diagReg <= pwdata[3:0];
    end else if (apbAcc && pwrite && paddr == `WBRA_OFF_PTRINIT) begin
      ptrInitReg <= pwdata[2:0];
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      if (paddr == `WBRA_OFF_DIAG) begin
        prdata = {28'h000_0000, diagReg};
      end else if (paddr == `WBRA_OFF_STATUS) begin
        prdata = {16'h0000, heldCand, pendReg, busyReg, drainReg, lastWrittenReg,
                  ptrReg, hitReg, wb_full};
      end else if (paddr == `WBRA_OFF_PTRINIT) begin
        prdata = {29'h0000_0000, ptrInitReg};
      end else if (paddr >= `WBRA_OFF_ENTRYBASE && paddr < 12'h020) begin
        prdata = {27'h000_0000, pendReg[paddr[3:2]], validEnt[paddr[3:2]]};
      end
    end
  end
endmodule

//--- hw/wbra_cfg.svh
// Purpose: Constants for the write buffer request and acknowledge block.
// Assumes: One beat clock, registers reached over APB.
// Notes:   Offsets are byte addresses of 32-bit words.
`ifndef WBRA_CFG_SVH
`define WBRA_CFG_SVH
`define WBRA_OFF_DIAG      12'h000
`define WBRA_OFF_STATUS    12'h004
`define WBRA_OFF_PTRINIT   12'h008
`define WBRA_OFF_ENTRYBASE 12'h010
`define WBRA_DIAG_SINGLE   0
`define WBRA_DIAG_DRAIN    1
`define WBRA_DIAG_LWDIS    2
`define WBRA_DIAG_BADPAR   3
`define WBRA_DIAG_RESET    4'h0
`define WBRA_PTRINIT_EN    2
`endif

//--- hw/wbra_pkg.sv
// Purpose: Types for the write buffer request and acknowledge block.
// Assumes: Nothing beyond the constants header.
// Notes:   Holds the request state and candidate class encodings.
package wbra_pkg;
  typedef enum logic [1:0] {
    WBRA_CLS_NONE  = 2'b00,
    WBRA_CLS_UNAL  = 2'b01,
    WBRA_CLS_AL32  = 2'b10,
    WBRA_CLS_AL64  = 2'b11
  } wbra_class_e;
  typedef enum logic [1:0] {
    WBRA_IDLE  = 2'b00,
    WBRA_WPOST = 2'b01,
    WBRA_RPOST = 2'b10
  } wbra_req_e;
endpackage

//--- tb/wbra_top_props.sv
// Purpose: Port-level checks for the write buffer block.
// Assumes: Diag register sits at offset zero, with bit 3 forcing address parity.
// Notes:   The parity bit is mirrored here because it is not visible at the ports.
`timescale 1ns/1ps
module wbra_top_props (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        dest_write_64,
  input wire logic        dest_write_32,
  input wire logic        cache_miss,
  input wire logic        mem_busy_n,
  input wire logic        mt_write_req,
  input wire logic        mt_read_req,
  input wire logic [3:0]  mem_addr_parity,
  input wire logic        abort_active
);
  logic badPar;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      badPar <= 1'b0;
    end else if (psel && penable && pwrite && paddr == 12'h000) begin
      badPar <= pwdata[3];
    end
  end
  a_busy_on_write: assert property (
    mem_busy_n && (dest_write_64 || dest_write_32) |=> !mem_busy_n)
    else $error("write did not set busy");
  a_busy_on_read: assert property (
    mem_busy_n && !dest_write_64 && !dest_write_32 && cache_miss |=> !mem_busy_n)
    else $error("read did not set busy");
  a_busy_release: assert property ($fell(mem_busy_n) |-> ##[2:400] mem_busy_n)
    else $error("busy never released");
  a_parity_forced: assert property (
    badPar && $past(badPar) && mt_write_req && $past(mt_write_req) |-> mem_addr_parity == 4'hF)
    else $error("parity not forced");
  a_req_exclusive: assert property (!(mt_write_req && mt_read_req))
    else $error("read and write request together");
  a_reset_clear: assert property (disable iff (1'b0)
    sys_rst |=> mem_busy_n && !mt_write_req && !mt_read_req && !abort_active)
    else $error("reset left activity");
  a_unmapped_err: assert property (
    psel && penable && (paddr == 12'h00C || paddr >= 12'h020) |-> pslverr)
    else $error("unmapped access not refused");
  a_abort_span: assert property ($rose(abort_active) |-> abort_active[*4])
    else $error("abort shorter than chain");
  c_write_req: cover property (mt_write_req);
  c_bad_parity: cover property (badPar && mt_write_req);
  c_refused: cover property (psel && penable && pslverr);
endmodule

//--- tb/wbra_mt_model.sv
// Purpose: Behavioural memory timer facing the write buffer.
// Assumes: One access at a time; lat sets how long each access lasts.
// Notes:   A cool-down skips the stale request still standing after a done pulse.
`timescale 1ns/1ps
module wbra_mt_model (
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       mt_write_req,
  input wire logic       mt_read_req,
  input wire logic       cpu_read,
  input wire logic [1:0] mt_req_ptr,
  input wire logic [7:0] lat,
  output logic           mt_busy_with_wb,
  output logic           mt_done,
  output logic     [1:0] mt_done_ptr
);
  logic [7:0] cnt;
  logic [1:0] cool;
  logic [1:0] ptrReg;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt <= 8'h00;
      cool <= 2'h0;
      ptrReg <= 2'h0;
      mt_busy_with_wb <= 1'b0;
      mt_done <= 1'b0;
    end else begin
      mt_done <= 1'b0;
      if (cool != 2'h0) begin
        cool <= cool - 2'h1;
      end
      if (mt_busy_with_wb) begin
        if (cnt == 8'h00) begin
          mt_busy_with_wb <= 1'b0;
          mt_done <= 1'b1;
          cool <= 2'h3;
        end else begin
          cnt <= cnt - 8'h01;
        end
      end else if (cool == 2'h0 && (mt_write_req || mt_read_req || cpu_read)) begin
        mt_busy_with_wb <= 1'b1;
        cnt <= lat;
        ptrReg <= mt_req_ptr;
      end
    end
  end
  // The pointer is meaningless outside the done pulse, so it never holds its last value there.
  assign mt_done_ptr = mt_done ? ptrReg : ~ptrReg;
endmodule

//--- tb/wbra_top_test.sv
// Purpose: Self-checking bench for the write buffer block.
// Assumes: APB slave answers at once; memory timer model serves requests.
// Notes:   Entry slots are discovered from the registers, never assumed.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module wbra_top_test;
  logic        ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, cpu_data_bus;
  logic        dest_write_64, dest_write_32, cache_miss, fast_read_64_cmd, dest_half;
  logic        half_odd, mt_busy_with_wb, mt_done, mem_busy_n, mt_write_req, mt_read_req;
  logic        mt_write_64, mt_write_odd, wb_full, abort_active;
  logic [28:0] cpu_address_bus, memory_address_bus;
  logic [1:0]  mt_done_ptr, mt_req_ptr;
  logic [3:0]  mem_addr_parity;
  logic [7:0]  lat;
  logic [4:0]  ent [4];
  int          failures, checks, cyc, pendCnt, p0, p1, k;
  wbra_top i_wbra_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dest_write_64(dest_write_64), .dest_write_32(dest_write_32),
    .cache_miss(cache_miss), .fast_read_64_cmd(fast_read_64_cmd), .dest_half(dest_half),
    .half_odd(half_odd), .cpu_address_bus(cpu_address_bus), .cpu_data_bus(cpu_data_bus),
    .mt_busy_with_wb(mt_busy_with_wb), .mt_done(mt_done), .mt_done_ptr(mt_done_ptr),
    .mem_busy_n(mem_busy_n), .mt_write_req(mt_write_req), .mt_read_req(mt_read_req),
    .mt_write_64(mt_write_64), .mt_write_odd(mt_write_odd), .mt_req_ptr(mt_req_ptr),
    .wb_full(wb_full), .abort_active(abort_active), .mem_addr_parity(mem_addr_parity),
    .memory_address_bus(memory_address_bus));
  wbra_mt_model i_wbra_mt_model (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .mt_write_req(mt_write_req), .mt_read_req(mt_read_req),
    .cpu_read(cache_miss || fast_read_64_cmd), .mt_req_ptr(mt_req_ptr), .lat(lat),
    .mt_busy_with_wb(mt_busy_with_wb), .mt_done(mt_done), .mt_done_ptr(mt_done_ptr));
  always #50 ref_clk = ~ref_clk;
  task test_done;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // The run should take a few hundred cycles; the ceiling leaves ample margin.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    logic done;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Answer is read while settled, so it equals what the edge samples.
    do begin
      @(negedge ref_clk);
      rd = prdata;
      err = pslverr;
      done = pready;
      @(posedge ref_clk);
      n++;
    end while (done !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd_ents;
    pendCnt = 0;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'h010 + 12'(i * 4), 32'h0000_0000);
      ent[i] = rd[4:0];
      pendCnt += int'(rd[4]);
    end
  endtask
  task cpu_wr(input logic w64, input logic [28:0] a);
    @(posedge ref_clk);
    dest_write_64 <= w64;
    dest_write_32 <= !w64;
    cpu_address_bus <= a;
    cpu_data_bus <= {3'b000, a};
    @(posedge ref_clk);
    dest_write_64 <= 1'b0;
    dest_write_32 <= 1'b0;
    @(negedge ref_clk);
    `CHK(mem_busy_n, 1'b0)
  endtask
  task settle;
    int n, q;
    n = 0;
    q = 0;
    while (q < 8 && n < 500) begin
      @(negedge ref_clk);
      n++;
      q = (mem_busy_n && !mt_write_req && !mt_read_req && !mt_busy_with_wb) ? q + 1 : 0;
    end
  endtask
  task wait_req;
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (mt_write_req !== 1'b1 && n < 100);
  endtask
  initial begin
    {ref_clk, psel, penable, pwrite, dest_write_64, dest_write_32, cache_miss} = '0;
    {fast_read_64_cmd, dest_half, half_odd, paddr, pwdata, cpu_address_bus} = '0;
    {cpu_data_bus, failures, checks, cyc} = '0;
    sys_rst = 1'b1;
    lat = 8'd10;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    rd_ents();
    `CHK(pendCnt, 0)
    apb(1'b1, 12'h020, 32'h0000_0001);
    `CHK(err, 1'b1)
    apb(1'b0, 12'h00C, 32'h0000_0000);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    apb(1'b1, 12'h000, 32'h0000_000F);
    apb(1'b0, 12'h000, 32'h0000_0000);
    `CHK(rd[3:0], 4'hF)
    apb(1'b1, 12'h000, 32'h0000_0000);
    apb(1'b1, 12'h008, 32'h0000_0007);
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK(rd[3:2], 2'b11)
    apb(1'b1, 12'h008, 32'h0000_0000);
    $display("test registers done");
    // A write issued while a read holds busy must vanish without trace.
    for (k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      cache_miss <= (k == 0);
      fast_read_64_cmd <= (k == 1);
      @(posedge ref_clk);
      cache_miss <= 1'b0;
      fast_read_64_cmd <= 1'b0;
      dest_write_64 <= 1'b1;
      @(negedge ref_clk);
      `CHK(mem_busy_n, 1'b0)
      @(posedge ref_clk);
      dest_write_64 <= 1'b0;
      settle();
    end
    rd_ents();
    `CHK(pendCnt, 0)
    $display("test read done");
    lat <= 8'd3;
    cpu_wr(1'b1, 29'h0000_0100);
    settle();
    rd_ents();
    p0 = 0;
    for (k = 0; k < 4; k++) p0 = (ent[k] == 5'h1F) ? k : p0;
    `CHK(ent[p0], 5'h1F)
    `CHK(pendCnt, 1)
    `CHK(mt_write_req, 1'b0)
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK(rd[5:4], p0[1:0])
    cpu_wr(1'b1, 29'h0000_0200);
    wait_req();
    `CHK({mt_write_64, mt_write_odd, mt_req_ptr}, {1'b1, 1'b0, p0[1:0]})
    settle();
    rd_ents();
    `CHK(ent[p0], 5'h0F)
    p1 = 0;
    for (k = 0; k < 4; k++) p1 = (ent[k] == 5'h1F) ? k : p1;
    cpu_wr(1'b0, 29'h0000_0200);
    settle();
    rd_ents();
    `CHK(pendCnt, 1)
    `CHK(ent[p1], 5'h1F)
    $display("test write chain done");
    for (k = 0; k < 2; k++) begin
      apb(1'b1, 12'h000, (k == 0) ? 32'h0000_0002 : 32'h0000_0004);
      settle();
      rd_ents();
      `CHK(pendCnt, 0)
      apb(1'b1, 12'h000, 32'h0000_0000);
      cpu_wr(1'b1, 29'h0000_0300 + 29'(k));
      settle();
    end
    `CHK(wb_full, 1'b0)
    apb(1'b1, 12'h000, 32'h0000_0001);
    repeat (2) @(negedge ref_clk);
    `CHK(wb_full, 1'b1)
    apb(1'b1, 12'h000, 32'h0000_000C);
    wait_req();
    @(negedge ref_clk);
    `CHK(mem_addr_parity, 4'hF)
    settle();
    apb(1'b1, 12'h000, 32'h0000_0000);
    $display("test diagnostics done");
    test_done();
  end
endmodule
bind wbra_top wbra_top_props i_wbra_top_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pslverr(pslverr), .dest_write_64(dest_write_64), .dest_write_32(dest_write_32),
  .cache_miss(cache_miss), .mem_busy_n(mem_busy_n), .mt_write_req(mt_write_req),
  .mt_read_req(mt_read_req), .mem_addr_parity(mem_addr_parity),
  .abort_active(abort_active));
